// >>> logic/arc_pkg.sv
// Package for the conversion result calibration stage
package arc_pkg;
  localparam int RAW_W = 12;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 14;
  localparam int OFFS_W = 16;
  localparam int LATENCY = 14;
  localparam int FADDR_W = 8;
  localparam logic [FADDR_W-1:0] GAIN_ADDR = 8'h00;
  localparam logic [FADDR_W-1:0] OFFS_ADDR = 8'h01;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h4000;
  localparam logic [OFFS_W-1:0] OFFS_ZERO = 16'h0000;
  localparam logic [RAW_W-1:0] RAW_MAX = 12'hFFF;
  localparam logic [RAW_W-1:0] RAW_MIN = 12'h000;
  localparam int VREF_MV = 2560;

  typedef enum logic [1:0] {
    FS_GAIN_REQ = 2'b00,
    FS_GAIN_WAIT = 2'b01,
    FS_OFFS_WAIT = 2'b10,
    FS_READY = 2'b11
  } arc_fetch_t;

  typedef struct packed {
    logic valid;
    logic [RAW_W-1:0] value;
  } arc_sample_t;
endpackage

// >>> logic/arc_correct.sv
// Pipelined gain and offset correction with saturation policy
`timescale 1ns/1ps
module arc_correct
  import arc_pkg::*;
#(
  parameter int STAGES = LATENCY
)
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic bypass_sat_in,
  input wire logic [GAIN_W-1:0] gain_in,
  input wire logic [OFFS_W-1:0] offs_in,
  input wire arc_sample_t raw_in,
  output arc_sample_t res_out
);
  localparam int PW = RAW_W + GAIN_W + 2;
  logic signed [PW-1:0] prod;
  logic signed [PW-1:0] sum;
  logic [RAW_W-1:0] corr;
  logic sat;
  arc_sample_t pipe_q [STAGES];

  // Gain is unsigned fixed point; offset is signed raw counts
  always_comb
  begin
    prod = $signed({2'b00, gain_in}) * $signed({{(PW-RAW_W){1'b0}},
      raw_in.value});
    sum = (prod >>> GAIN_FRAC) + PW'($signed(offs_in));
    if (sum < 0)
      corr = RAW_MIN;
    else if (sum > PW'(RAW_MAX))
      corr = RAW_MAX;
    else
      corr = sum[RAW_W-1:0];
    sat = (raw_in.value == RAW_MAX) || (raw_in.value == RAW_MIN);
  end

  // Delay line gives the fixed latency; cost traded for timing slack
  genvar g;
  generate
    for (g = 0; g < STAGES; g++)
    begin : g_pipe
      if (g == 0)
      begin : g_head
        always_ff @(posedge clk_in or negedge rst_n_in)
        begin
          if (!rst_n_in)
            pipe_q[g] <= '0;
          else
          begin
            pipe_q[g].valid <= raw_in.valid;
            if (bypass_sat_in && sat)
              pipe_q[g].value <= raw_in.value;
            else
              pipe_q[g].value <= corr;
          end
        end
      end
      else
      begin : g_tail
        always_ff @(posedge clk_in or negedge rst_n_in)
        begin
          if (!rst_n_in)
            pipe_q[g] <= '0;
          else
            pipe_q[g] <= pipe_q[g-1];
        end
      end
    end
  endgenerate

  assign res_out = pipe_q[STAGES-1];
endmodule

// >>> logic/arc_top.sv
// Conversion result calibration stage top level
`timescale 1ns/1ps
// Functional notes
// - Output equals gain times raw plus offset
// - Coefficients fetched from flash automatically
// - Corrected value goes downstream, not raw
// - Always-correct mode corrects saturated inputs too
// - Bypass mode passes saturated raw unchanged
// - Correction adds fourteen clock cycles latency
// - Exported valid, busy, result come from here
// - Corrects only with 2.56V reference; others pass raw delayed
// - Unity gain, zero offset gives identity
module arc_top
  import arc_pkg::*;
#(
  parameter int VREF_SEL_MV = VREF_MV
)
(
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic BYPASS_SAT_IN,
  input wire logic RAW_VALID_IN,
  input wire logic [RAW_W-1:0] RAW_RESULT_IN,
  output logic FLASH_RD_OUT,
  output logic [FADDR_W-1:0] FLASH_ADDR_OUT,
  input wire logic FLASH_ACK_IN,
  input wire logic [GAIN_W-1:0] FLASH_DATA_IN,
  output logic COEF_READY_OUT,
  output logic RESULT_VALID_OUT,
  output logic BUSY_OUT,
  output logic [RAW_W-1:0] CONVERSION_RESULT_OUT
);
  arc_fetch_t fs_q;
  logic [GAIN_W-1:0] gain_q;
  logic [OFFS_W-1:0] offs_q;
  logic [RAW_W-1:0] res_q;
  logic valid_q;
  logic [4:0] pend_q;
  logic gain_take;
  logic offs_take;
  logic pend_up;
  logic pend_dn;
  arc_sample_t raw_s;
  arc_sample_t res_s;

  // Each coefficient is taken on the edge that sees the flash answer
  assign gain_take = (fs_q == FS_GAIN_WAIT) && FLASH_ACK_IN;
  assign offs_take = (fs_q == FS_OFFS_WAIT) && FLASH_ACK_IN;

  // Fetch runs once after every reset, gain word first
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      fs_q <= FS_GAIN_REQ;
    else
    begin
      case (fs_q)
        FS_GAIN_REQ:
          fs_q <= FS_GAIN_WAIT;
        FS_GAIN_WAIT:
          if (gain_take)
            fs_q <= FS_OFFS_WAIT;
        FS_OFFS_WAIT:
          if (offs_take)
            fs_q <= FS_READY;
        FS_READY:
          fs_q <= FS_READY;
        default:
          fs_q <= FS_GAIN_REQ;
      endcase
    end
  end

  // Unity gain until the flash answers, so early samples pass through
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      gain_q <= GAIN_UNITY;
    else if (gain_take)
      gain_q <= FLASH_DATA_IN;
  end

  // Offset word is read as signed counts by the datapath
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      offs_q <= OFFS_ZERO;
    else if (offs_take)
      offs_q <= FLASH_DATA_IN[OFFS_W-1:0];
  end

  // Read stays up through each wait; address parks on the gain word
  // Defaults first so every path drives all three outputs
  always_comb
  begin
    FLASH_RD_OUT = 1'b0;
    FLASH_ADDR_OUT = GAIN_ADDR;
    COEF_READY_OUT = 1'b0;
    case (fs_q)
      FS_GAIN_REQ:
      begin
        FLASH_RD_OUT = 1'b0;
        FLASH_ADDR_OUT = GAIN_ADDR;
      end
      FS_GAIN_WAIT:
      begin
        FLASH_RD_OUT = 1'b1;
        FLASH_ADDR_OUT = GAIN_ADDR;
      end
      FS_OFFS_WAIT:
      begin
        FLASH_RD_OUT = 1'b1;
        FLASH_ADDR_OUT = OFFS_ADDR;
      end
      FS_READY:
        COEF_READY_OUT = 1'b1;
      default:
      begin
        FLASH_RD_OUT = 1'b0;
        FLASH_ADDR_OUT = GAIN_ADDR;
      end
    endcase
  end

  // Samples before coefficients load use unity values
  assign raw_s.valid = RAW_VALID_IN;
  assign raw_s.value = RAW_RESULT_IN;

  // Stored coefficients only hold for the internal reference; with any
  // other reference the stage is left out and raw values are delayed
  generate
    if (VREF_SEL_MV == VREF_MV)
    begin : g_cal
      arc_correct #(
        .STAGES(LATENCY - 1)
      ) u_corr (
        .clk_in(MCLK_IN),
        .rst_n_in(RST_N_IN),
        .bypass_sat_in(BYPASS_SAT_IN),
        .gain_in(gain_q),
        .offs_in(offs_q),
        .raw_in(raw_s),
        .res_out(res_s)
      );
    end
    else
    begin : g_raw
      // Same depth as the calibrated path so downstream timing holds
      arc_sample_t dly_q [LATENCY-1];
      for (genvar k = 0; k < LATENCY - 1; k++)
      begin : g_dly
        if (k == 0)
        begin : g_head
          always_ff @(posedge MCLK_IN or negedge RST_N_IN)
          begin
            if (!RST_N_IN)
              dly_q[k] <= '0;
            else
              dly_q[k] <= raw_s;
          end
        end
        else
        begin : g_tail
          always_ff @(posedge MCLK_IN or negedge RST_N_IN)
          begin
            if (!RST_N_IN)
              dly_q[k] <= '0;
            else
              dly_q[k] <= dly_q[k-1];
          end
        end
      end
      assign res_s = dly_q[LATENCY-2];
    end
  endgenerate

  // Valid is a single-cycle strobe, one per sample taken
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      valid_q <= 1'b0;
    else
      valid_q <= res_s.valid;
  end

  // Result holds between strobes so a slow reader still sees it
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      res_q <= '0;
    else if (res_s.valid)
      res_q <= res_s.value;
  end

  // Count samples in flight; several may overlap in the pipe
  assign pend_up = RAW_VALID_IN && !valid_q;
  assign pend_dn = !RAW_VALID_IN && valid_q;

  // One sample in and one out in the same cycle leave the count alone
  always_ff @(posedge MCLK_IN or negedge RST_N_IN)
  begin
    if (!RST_N_IN)
      pend_q <= '0;
    else
    begin
      case ({pend_up, pend_dn})
        2'b10:
          pend_q <= pend_q + 5'h01;
        2'b01:
          pend_q <= pend_q - 5'h01;
        default:
          pend_q <= pend_q;
      endcase
    end
  end

  // Exported handshake and result belong to this stage
  assign BUSY_OUT = (pend_q != 5'h00);
  assign RESULT_VALID_OUT = valid_q;
  assign CONVERSION_RESULT_OUT = res_q;
endmodule

// >>> verification/arc_top_monitor.sv
// Port assertions for the calibration stage
`timescale 1ns/1ps
module arc_top_monitor
  import arc_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_N_IN,
  input wire logic BYPASS_SAT_IN,
  input wire logic RAW_VALID_IN,
  input wire logic [RAW_W-1:0] RAW_RESULT_IN,
  input wire logic FLASH_RD_OUT,
  input wire logic [FADDR_W-1:0] FLASH_ADDR_OUT,
  input wire logic FLASH_ACK_IN,
  input wire logic COEF_READY_OUT,
  input wire logic RESULT_VALID_OUT,
  input wire logic BUSY_OUT,
  input wire logic [RAW_W-1:0] CONVERSION_RESULT_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  wire logic tk = FLASH_RD_OUT && FLASH_ACK_IN;
  wire logic sat = RAW_RESULT_IN == RAW_MIN || RAW_RESULT_IN == RAW_MAX;
  property p_lat; RAW_VALID_IN |-> ##14 RESULT_VALID_OUT; endproperty
  a_lat: assert property (p_lat) else $error("late result");
  property p_one; !RAW_VALID_IN |-> ##14 !RESULT_VALID_OUT; endproperty
  a_one: assert property (p_one) else $error("extra result");
  property p_bsy; RAW_VALID_IN |=> BUSY_OUT [*8]; endproperty
  a_bsy: assert property (p_bsy) else $error("busy low");
  property p_hld; !RESULT_VALID_OUT |-> $stable(CONVERSION_RESULT_OUT);
  endproperty
  a_hld: assert property (p_hld) else $error("result moved");
  property p_rd; FLASH_RD_OUT && !FLASH_ACK_IN |=>
    FLASH_RD_OUT && $stable(FLASH_ADDR_OUT); endproperty
  a_rd: assert property (p_rd) else $error("read dropped");
  property p_ord; tk && FLASH_ADDR_OUT == GAIN_ADDR |=>
    FLASH_ADDR_OUT == OFFS_ADDR; endproperty
  a_ord: assert property (p_ord) else $error("bad order");
  property p_rdy; tk && FLASH_ADDR_OUT == OFFS_ADDR |=>
    COEF_READY_OUT && !FLASH_RD_OUT; endproperty
  a_rdy: assert property (p_rdy) else $error("not ready");
  property p_byp; RAW_VALID_IN && BYPASS_SAT_IN && sat |-> ##14
    CONVERSION_RESULT_OUT == $past(RAW_RESULT_IN, 14); endproperty
  a_byp: assert property (p_byp) else $error("no bypass");
endmodule

// >>> verification/arc_flash_model.sv
// Flash model answering coefficient reads
`timescale 1ns/1ps
module arc_flash_model
  import arc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic [FADDR_W-1:0] addr_in,
  input wire logic [GAIN_W-1:0] gain_in,
  input wire logic [OFFS_W-1:0] offs_in,
  output logic ack_out,
  output logic [GAIN_W-1:0] data_out
);
  logic [GAIN_W-1:0] word;
  assign word = addr_in == GAIN_ADDR ? gain_in : offs_in;
  // Inverted outside the ack so a stale word is never taken
  assign data_out = ack_out ? word : ~word;
  always_ff @(posedge clk_in)
  begin
    ack_out <= rd_in && !ack_out;
  end
endmodule

// >>> verification/arc_top_test.sv
// Self-checking bench for the calibration stage
`timescale 1ns/1ps
module arc_top_test;
  import arc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic byp = 1'b0;
  logic rv = 1'b0;
  logic [RAW_W-1:0] raw = 12'h000;
  logic [GAIN_W-1:0] gain = 16'h3800;
  logic [OFFS_W-1:0] offs = 16'h0010;
  logic rd, ack, rdy, vld, busy;
  logic [FADDR_W-1:0] addr;
  logic [GAIN_W-1:0] fd;
  logic [RAW_W-1:0] res;
  logic [RAW_W-1:0] exp_q[$];
  int n_mismatch = 0;
  int check_count = 0;
  arc_top uut (.MCLK_IN(clk), .RST_N_IN(rst_n), .BYPASS_SAT_IN(byp),
    .RAW_VALID_IN(rv), .RAW_RESULT_IN(raw), .FLASH_RD_OUT(rd),
    .FLASH_ADDR_OUT(addr), .FLASH_ACK_IN(ack), .FLASH_DATA_IN(fd),
    .COEF_READY_OUT(rdy), .RESULT_VALID_OUT(vld), .BUSY_OUT(busy),
    .CONVERSION_RESULT_OUT(res));
  arc_flash_model fm (.clk_in(clk), .rd_in(rd), .addr_in(addr),
    .gain_in(gain), .offs_in(offs), .ack_out(ack), .data_out(fd));
  initial forever #5 clk = ~clk;
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [RAW_W-1:0] got, want);
    check_count++;
    if (got !== want)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, want);
    end
  endtask
  // A result with nothing pending is compared against its own inverse
  always @(posedge clk)
    if (vld === 1'b1)
      check(res, exp_q.size() ? exp_q.pop_front() : ~res);
  task automatic boot();
    int i;
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 20 && rdy !== 1'b1; i++) @(posedge clk);
    check({11'h0, rdy}, 12'h001);
  endtask
  task automatic burst(input logic [RAW_W-1:0] a, b, c, input logic s,
    input string n);
    logic [RAW_W-1:0] v[3];
    int i;
    int y;
    v = '{a, b, c};
    for (i = 0; i < 3; i++)
    begin
      y = (int'(gain) * int'(v[i]) >> GAIN_FRAC) + int'($signed(offs));
      y = y < 0 ? 0 : (y > int'(RAW_MAX) ? int'(RAW_MAX) : y);
      if (s && (v[i] == RAW_MIN || v[i] == RAW_MAX))
        y = int'(v[i]);
      exp_q.push_back(RAW_W'(y));
      rv <= 1'b1;
      raw <= v[i];
      byp <= s;
      @(posedge clk);
    end
    rv <= 1'b0;
    check({11'h0, busy}, 12'h001);
    for (i = 0; i < 30 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t left %h want %h", $time, exp_q.size(), 0);
      final_report();
    end
    @(posedge clk);
    check({11'h0, busy}, 12'h000);
    $display("%s done", n);
  endtask
  task automatic t_corr();
    burst(12'h000, 12'hFFF, 12'h7A3, 1'b0, "correct");
  endtask
  task automatic t_byp();
    burst(12'hFFF, 12'h000, 12'h100, 1'b1, "bypass");
  endtask
  task automatic t_ident();
    gain <= GAIN_UNITY;
    offs <= OFFS_ZERO;
    boot();
    burst(12'h000, 12'h5A5, 12'hFFF, 1'b0, "identity");
  endtask
  initial
  begin
    boot();
    t_corr();
    t_byp();
    t_ident();
    final_report();
  end
endmodule
bind arc_top arc_top_monitor mon (.*);
